// File: design/clock_mode_map.svh
// Overview of operation
// - divider mode derives internal clocks by dividing the reference clock by two or four
// - pll mode multiplies the reference by one of 31 selectable ratios
// - divider mode offers divide by 2 or 4; pll may be powered down
// - programmable lock timer holds off the switch to pll clocking until lock
// - pll first acquires lock, then keeps tracking the input
// - 16-bit software-writable clock mode register at address 0058h
// - reset value of the clock mode register depends only on the three mode pins
// - pins 0,0,0 reset the register to 0000h, pll and oscillator off
// - pins 0,0,1 reset the register to 9007h, pll times ten, oscillator on
// - pins 0,1,0 reset the register to 4007h, pll times five, oscillator on
// - pins 1,0,0 reset the register to 1007h, pll times two, oscillator on
// - pins 1,1,0 reset the register to f007h, pll times one, oscillator on
// - pins 1,1,1 reset the register to 0000h, pll off, oscillator on
// - pins 1,0,1 reset the register to f000h, divide by four, oscillator on
// - mode pins are sampled while reset is held; the outside keeps them steady
// - software writes after reset reconfigure the clock generation mode
// - oscillator enable always follows the pins; other settings ignore later pin changes
`ifndef CLOCK_MODE_MAP_SVH
`define CLOCK_MODE_MAP_SVH

// register address and data width
`define CLK_MODE_ADDR 16'h0058
`define CLK_MODE_W 16

// field positions inside the clock mode register
`define CLK_MUL_HI 15
`define CLK_MUL_LO 12
`define CLK_HALF_BIT 11
`define CLK_COUNT_HI 10
`define CLK_COUNT_LO 3
`define CLK_ONOFF_BIT 2
`define CLK_NDIV_BIT 1
`define CLK_STATUS_BIT 0

// multiplier code that selects unity gain, or divide by four in divider mode
`define CLK_MUL_QUARTER 4'hf

// reset values chosen by the mode pins
`define CLK_RST_000 16'h0000
`define CLK_RST_001 16'h9007
`define CLK_RST_010 16'h4007
`define CLK_RST_100 16'h1007
`define CLK_RST_110 16'hf007
`define CLK_RST_111 16'h0000
`define CLK_RST_101 16'hf000
`define CLK_RST_011 16'h0000

// pin pattern that switches the oscillator off
`define CLK_PINS_OSC_OFF 3'b000

// lock timer: reference cycles per unit of the lock count field
`define CLK_LOCK_TICK 12'h010
`define CLK_LOCK_W 12

`endif

// File: design/clock_mode_pkg.sv
package clock_mode_pkg;

   // clocking state of the generator
   typedef enum logic [1:0] {
      ST_DIV = 2'b00,
      ST_ACQUIRE = 2'b01,
      ST_LOCKED = 2'b10
   } pll_state_t;

   // state of the lock timer
   typedef struct packed {
      logic [11:0] cnt;
      logic busy;
      logic done;
   } lock_timer_t;

   // state of the clock mode generator
   typedef struct packed {
      logic [2:0] pinSync1;
      logic [2:0] pinSync2;
      logic [15:1] modeReg;
      pll_state_t state;
      logic divCnt;
      logic divClk;
      logic divQuarter;
      logic selPll;
      logic divClkOut;
      logic [15:0] rdData;
      logic rdValid;
      logic oscEn;
      logic pllOn;
      logic [3:0] mul;
      logic half;
      logic locked;
   } clk_gen_t;

endpackage

// File: design/pll_clock_mode_generator.sv
`timescale 1ns/100ps
`include "clock_mode_map.svh"

module pll_clock_mode_generator
   import clock_mode_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter logic [11:0] LOCK_TICK = `CLK_LOCK_TICK
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic modeSelectPinOne,
   input wire logic modeSelectPinTwo,
   input wire logic modeSelectPinThree,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic memWrite,
   input wire logic memRead,
   input wire logic [15:0] memWrData,
   output logic [15:0] memRdData,
   output logic memRdValid,
   output logic oscEnable,
   output logic pllPowerOn,
   output logic [3:0] pllMultiplier,
   output logic pllHalfRatio,
   output logic pllLocked,
   output logic masterSelPll,
   output logic divClkOut
);

   clk_gen_t gen_reg;
   clk_gen_t gen_next;
   logic timerStart;
   logic timerDone;
   logic [15:0] strapVal;
   logic wrHit;
   logic divFall;

   // clock mode register value selected by the pins at reset
   function automatic logic [15:0] strapValue(input logic [2:0] pins);
      logic [15:0] val;
      val = `CLK_RST_000;
      case (pins)
         3'b000: val = `CLK_RST_000;
         3'b001: val = `CLK_RST_001;
         3'b010: val = `CLK_RST_010;
         3'b100: val = `CLK_RST_100;
         3'b110: val = `CLK_RST_110;
         3'b111: val = `CLK_RST_111;
         3'b101: val = `CLK_RST_101;
         3'b011: val = `CLK_RST_011;
         default: val = `CLK_RST_000;
      endcase
      return val;
   endfunction

   // address match for the clock mode register
   function automatic logic isModeAddr(input logic [ADDR_W-1:0] addr);
      return (addr == ADDR_W'(`CLK_MODE_ADDR));
   endfunction

   // divider ratio is a quarter when the multiplier field holds all ones
   function automatic logic quarterRatio(input logic [3:0] mulField);
      return (mulField == `CLK_MUL_QUARTER);
   endfunction

   // timer that holds off pll clocking until lock
   pll_lock_timer #(
      .LOCK_TICK(LOCK_TICK)
   ) u_lock_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .clkEn(clkEn),
      .start(timerStart),
      .lockCount(memWrData[`CLK_COUNT_HI:`CLK_COUNT_LO]),
      .busy(),
      .done(timerDone)
   );

   // next-state logic for the whole generator
   always_comb begin
      gen_next = gen_reg;
      timerStart = 1'b0;
      strapVal = strapValue(gen_reg.pinSync2);
      wrHit = memWrite && isModeAddr(memAddr);
      divFall = gen_reg.divClk && (!gen_reg.divQuarter || gen_reg.divCnt);
      if (clkEn) begin
         // mode pins cross in through two flip-flops
         gen_next.pinSync1 = {modeSelectPinOne, modeSelectPinTwo, modeSelectPinThree};
         gen_next.pinSync2 = gen_reg.pinSync1;

         // oscillator enable tracks the pins in and out of reset
         gen_next.oscEn = (gen_reg.pinSync2 != `CLK_PINS_OSC_OFF);
         gen_next.rdValid = 1'b0;

         if (rst) begin
            // register loads from the pins for as long as reset is held
            gen_next.modeReg = strapVal[15:1];
            gen_next.state = strapVal[`CLK_NDIV_BIT] ? ST_LOCKED : ST_DIV;
            gen_next.selPll = strapVal[`CLK_NDIV_BIT];
            gen_next.divCnt = 1'b0;
            gen_next.divClk = 1'b0;
            gen_next.divQuarter = quarterRatio(strapVal[`CLK_MUL_HI:`CLK_MUL_LO]);
            gen_next.rdData = 16'h0000;
         end else begin
            // software write; later pin changes no longer reach these bits
            if (wrHit) begin
               gen_next.modeReg = memWrData[15:1];
            end

            // read returns stored bits plus live pll status
            if (memRead) begin
               gen_next.rdValid = 1'b1;
               if (isModeAddr(memAddr)) begin
                  gen_next.rdData = {gen_reg.modeReg, (gen_reg.state == ST_LOCKED)};
               end else begin
                  gen_next.rdData = 16'h0000;
               end
            end

            // clocking state machine
            case (gen_reg.state)
               ST_DIV: begin
                  if (wrHit && memWrData[`CLK_NDIV_BIT]) begin
                     gen_next.state = ST_ACQUIRE;
                     timerStart = 1'b1;
                  end
               end
               ST_ACQUIRE: begin
                  if (wrHit && !memWrData[`CLK_NDIV_BIT]) begin
                     gen_next.state = ST_DIV;
                  end else if (wrHit) begin
                     timerStart = 1'b1;
                  end else if (timerDone) begin
                     gen_next.state = ST_LOCKED;
                  end
               end
               ST_LOCKED: begin
                  if (wrHit && !memWrData[`CLK_NDIV_BIT]) begin
                     gen_next.state = ST_DIV;
                  end else if (wrHit) begin
                     // new ratio needs a fresh acquisition
                     gen_next.state = ST_ACQUIRE;
                     timerStart = 1'b1;
                  end
               end
               default: begin
                  gen_next.state = ST_DIV;
               end
            endcase

            // divider: halves the reference, or quarters it on request
            if (divFall) begin
               gen_next.divClk = 1'b0;
               gen_next.divCnt = 1'b0;
               // ratio changes only at a falling edge so no phase is cut short
               gen_next.divQuarter = quarterRatio(gen_reg.modeReg[`CLK_MUL_HI:`CLK_MUL_LO]);
            end else if (gen_reg.divClk) begin
               gen_next.divCnt = 1'b1;
            end else if (!gen_reg.divQuarter || gen_reg.divCnt) begin
               gen_next.divClk = 1'b1;
               gen_next.divCnt = 1'b0;
            end else begin
               gen_next.divCnt = 1'b1;
            end

            // source select moves only while the divided clock is low
            if (!gen_reg.divClk) begin
               gen_next.selPll = (gen_reg.state == ST_LOCKED);
            end
         end

         // divided clock is gated off while the pll drives the master clock
         gen_next.divClkOut = gen_next.divClk && !gen_next.selPll;

         // pll controls from the register fields
         gen_next.pllOn = gen_next.modeReg[`CLK_ONOFF_BIT] || gen_next.modeReg[`CLK_NDIV_BIT];
         gen_next.mul = gen_next.modeReg[`CLK_MUL_HI:`CLK_MUL_LO];
         gen_next.half = gen_next.modeReg[`CLK_HALF_BIT];
         gen_next.locked = (gen_next.state == ST_LOCKED);
      end
   end

   // single register for all generator state except the lock timer, which keeps its own
   always_ff @(posedge ref_clk) begin
      gen_reg <= gen_next;
   end

   // outputs straight from flip-flops
   assign memRdData = gen_reg.rdData;
   assign memRdValid = gen_reg.rdValid;
   assign oscEnable = gen_reg.oscEn;
   assign pllPowerOn = gen_reg.pllOn;
   assign pllMultiplier = gen_reg.mul;
   assign pllHalfRatio = gen_reg.half;
   assign pllLocked = gen_reg.locked;
   assign masterSelPll = gen_reg.selPll;
   assign divClkOut = gen_reg.divClkOut;

endmodule

// File: design/pll_lock_timer.sv
`timescale 1ns/100ps
`include "clock_mode_map.svh"

module pll_lock_timer
   import clock_mode_pkg::*;
#(
   parameter logic [11:0] LOCK_TICK = `CLK_LOCK_TICK
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic start,
   input wire logic [7:0] lockCount,
   output logic busy,
   output logic done
);

   lock_timer_t timer_reg;
   lock_timer_t timer_next;

   // load on start, count down, flag expiry until the next start
   always_comb begin
      timer_next = timer_reg;
      if (rst) begin
         timer_next = '0;
      end else if (clkEn) begin
         if (start) begin
            timer_next.cnt = 12'(lockCount) * LOCK_TICK;
            timer_next.busy = (lockCount != 8'h00);
            timer_next.done = (lockCount == 8'h00);
         end else if (timer_reg.busy) begin
            timer_next.cnt = timer_reg.cnt - 12'h001;
            if (timer_reg.cnt == 12'h001) begin
               timer_next.busy = 1'b0;
               timer_next.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      timer_reg <= timer_next;
   end

   assign busy = timer_reg.busy;
   assign done = timer_reg.done;

endmodule

// File: testbench/clk_mode_monitor.sv
`timescale 1ns/100ps
module clk_mode_monitor
   import clock_mode_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter logic [11:0] LOCK_TICK = 12'h010
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic modeSelectPinOne,
   input wire logic modeSelectPinTwo,
   input wire logic modeSelectPinThree,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic memWrite,
   input wire logic memRead,
   input wire logic [15:0] memWrData,
   input wire logic [15:0] memRdData,
   input wire logic memRdValid,
   input wire logic oscEnable,
   input wire logic pllPowerOn,
   input wire logic [3:0] pllMultiplier,
   input wire logic pllHalfRatio,
   input wire logic pllLocked,
   input wire logic masterSelPll,
   input wire logic divClkOut
);
   logic hit;
   logic [2:0] pins;
   logic [15:0] wdLast;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // address decode and pin bundle
   assign hit = memAddr == ADDR_W'(16'h0058);
   assign pins = {modeSelectPinOne, modeSelectPinTwo, modeSelectPinThree};
   // last write data
   always_ff @(posedge ref_clk) begin
      wdLast <= memWrData;
   end
   sequence s_wr_pll;
      clkEn && memWrite && hit && memWrData[1];
   endsequence
   sequence s_wr_n1;
      s_wr_pll ##0 memWrData[10:3] == 8'h01;
   endsequence
   a_read_answer: assert property (clkEn |=> memRdValid == $past(memRead))
      else $error("read answer wrong");
   a_unmapped_zero: assert property (clkEn && memRead && !hit |=> memRdData == 16'h0000)
      else $error("unmapped read not zero");
   a_read_hold: assert property (!memRead |=> $stable(memRdData))
      else $error("read data moved");
   a_write_fields: assert property (clkEn && memWrite && hit |=>
      {pllMultiplier, pllHalfRatio, pllPowerOn} == {wdLast[15:11], wdLast[2] | wdLast[1]})
      else $error("fields not updated");
   a_osc_pins: assert property (($stable(pins) && clkEn)[*4] |-> oscEnable == (pins != 3'b000))
      else $error("oscillator enable wrong");
   a_acq_restart: assert property (s_wr_pll |=> !pllLocked)
      else $error("no acquisition phase");
   a_lock_time: assert property (s_wr_n1 |=> (!pllLocked)[*8] ##[7:10] pllLocked)
      else $error("lock time wrong");
   a_sel_locked: assert property ($rose(masterSelPll) |-> pllLocked)
      else $error("pll selected before lock");
   a_div_unlock: assert property (clkEn && memWrite && hit && !memWrData[1] |=> !pllLocked)
      else $error("divider write kept lock");
   a_div_quiet: assert property (masterSelPll[*2] |-> !divClkOut)
      else $error("divider clock leaks");
   a_switch_clean: assert property ($rose(masterSelPll) |-> !$past(divClkOut))
      else $error("divider pulse cut at switch");
endmodule

bind pll_clock_mode_generator clk_mode_monitor #(.ADDR_W(ADDR_W), .LOCK_TICK(LOCK_TICK)) mon (
   .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .modeSelectPinOne(modeSelectPinOne),
   .modeSelectPinTwo(modeSelectPinTwo), .modeSelectPinThree(modeSelectPinThree), .memAddr(memAddr),
   .memWrite(memWrite), .memRead(memRead), .memWrData(memWrData), .memRdData(memRdData),
   .memRdValid(memRdValid), .oscEnable(oscEnable), .pllPowerOn(pllPowerOn), .pllMultiplier(pllMultiplier),
   .pllHalfRatio(pllHalfRatio), .pllLocked(pllLocked), .masterSelPll(masterSelPll), .divClkOut(divClkOut));

// File: testbench/mode_strap_source.sv
`timescale 1ns/100ps
module mode_strap_source (
   input wire logic [2:0] pattern,
   output logic pinOne,
   output logic pinTwo,
   output logic pinThree
);
   // straps hold the chosen levels steady
   assign {pinOne, pinTwo, pinThree} = pattern;
endmodule

// File: testbench/tb.sv
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic memWrite = 1'b0;
   logic memRead = 1'b0;
   logic [15:0] memAddr = 16'h0000;
   logic [15:0] memWrData = 16'h0000;
   logic [2:0] pattern = 3'b000;
   logic pinOne, pinTwo, pinThree, memRdValid, oscEnable, pllPowerOn, pllHalfRatio;
   logic pllLocked, masterSelPll, divClkOut;
   logic [15:0] memRdData;
   logic [3:0] pllMultiplier;
   logic [15:0] d;
   integer seed = 55;
   int num_errors = 0;
   int check_count = 0;
   int n;
   // reference clock
   always #5 ref_clk = ~ref_clk;
   mode_strap_source straps (.pattern(pattern), .pinOne(pinOne), .pinTwo(pinTwo), .pinThree(pinThree));
   pll_clock_mode_generator dut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .modeSelectPinOne(pinOne),
      .modeSelectPinTwo(pinTwo), .modeSelectPinThree(pinThree), .memAddr(memAddr), .memWrite(memWrite),
      .memRead(memRead), .memWrData(memWrData), .memRdData(memRdData), .memRdValid(memRdValid),
      .oscEnable(oscEnable), .pllPowerOn(pllPowerOn), .pllMultiplier(pllMultiplier),
      .pllHalfRatio(pllHalfRatio), .pllLocked(pllLocked), .masterSelPll(masterSelPll), .divClkOut(divClkOut));
   task check(input string nm, input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("MISMATCH %s exp=%h got=%h", nm, exp, got);
         num_errors++;
      end
   endtask
   task end_of_test;
      $display("errors=%0d checks=%0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // count rising edges of the divided clock over 16 cycles
   task count_rises(output int r);
      logic last;
      r = 0;
      last = divClkOut;
      repeat (16) begin
         @(negedge ref_clk);
         if (divClkOut && !last) r++;
         last = divClkOut;
      end
   endtask
   task wr(input logic [15:0] a, input logic [15:0] v);
      @(negedge ref_clk);
      memAddr = a;
      memWrData = v;
      memWrite = 1'b1;
      @(negedge ref_clk);
      memWrite = 1'b0;
   endtask
   task rdchk(input logic [15:0] a, input logic [15:0] exp);
      @(negedge ref_clk);
      memAddr = a;
      memRead = 1'b1;
      @(negedge ref_clk);
      memRead = 1'b0;
      check("rdValid", 16'(memRdValid), 16'h0001);
      check("rdData", memRdData, exp);
   endtask
   task reset_with(input logic [2:0] p);
      @(negedge ref_clk);
      pattern = p;
      rst = 1'b1;
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
   endtask
   // reset value per pin pattern
   function logic [15:0] reset_value(input logic [2:0] p);
      case (p)
         3'b001: return 16'h9007;
         3'b010: return 16'h4007;
         3'b100: return 16'h1007;
         3'b110: return 16'hf007;
         3'b101: return 16'hf000;
         default: return 16'h0000;
      endcase
   endfunction
   // watchdog
   initial begin
      #100000;
      num_errors++;
      end_of_test;
   end
   // main sequence
   initial begin
      for (int p = 0; p < 8; p++) begin
         reset_with(p[2:0]);
         rdchk(16'h0058, reset_value(p[2:0]));
         check("oscEnable", 16'(oscEnable), 16'(p != 0));
      end
      reset_with(3'b001);
      pattern = 3'b000;
      repeat (5) @(negedge ref_clk);
      check("oscOff", 16'(oscEnable), 16'h0000);
      rdchk(16'h0058, 16'h9007);
      pattern = 3'b110;
      repeat (5) @(negedge ref_clk);
      check("oscOn", 16'(oscEnable), 16'h0001);
      rdchk(16'h0058, 16'h9007);
      reset_with(3'b111);
      wr(16'h0058, 16'h000e);
      n = 0;
      while (pllLocked !== 1'b1 && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      check("lockTime", 16'(n >= 16 && n <= 17), 16'h0001);
      repeat (6) @(negedge ref_clk);
      check("selPll", 16'(masterSelPll), 16'h0001);
      rdchk(16'h0058, 16'h000f);
      wr(16'h0058, 16'h0000);
      repeat (6) @(negedge ref_clk);
      check("selDiv", 16'(masterSelPll), 16'h0000);
      // divided clock runs at half, then a quarter of the reference
      count_rises(n);
      check("div2", 16'(n), 16'h0008);
      wr(16'h0058, 16'hf000);
      repeat (4) @(negedge ref_clk);
      count_rises(n);
      check("div4", 16'(n), 16'h0004);
      // clock enable low freezes the divider and refuses writes
      @(negedge ref_clk);
      clkEn = 1'b0;
      d = 16'(divClkOut);
      wr(16'h0058, 16'h0000);
      repeat (3) @(negedge ref_clk);
      check("frozen", 16'(divClkOut), d);
      clkEn = 1'b1;
      rdchk(16'h0058, 16'hf000);
      for (int i = 0; i < 24; i++) begin
         d = 16'($random(seed));
         if (i == 0) d = 16'hffff;
         d[1] = 1'b0;
         wr(16'h0058, d);
         check("fields", 16'({pllMultiplier, pllHalfRatio, pllPowerOn}), 16'({d[15:11], d[2]}));
         wr(16'h0059, ~d);
         rdchk(16'h0058, d & 16'hfffe);
         rdchk(16'h0100, 16'h0000);
      end
      end_of_test;
   end
endmodule
